//--- hw/irqfb_pkg.sv
// Shared constants and types of the interrupt request and enable bank
package irqfb_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (low address byte decoded)
  // ----------------------------------------------------------------
  localparam int          ADDR_DEC_W       = 8;
  localparam logic [7:0]  OFS_EDGE_SELECT  = 8'h00;
  localparam logic [7:0]  OFS_CTRL_A       = 8'h04;
  localparam logic [7:0]  OFS_CTRL_B       = 8'h08;
  localparam logic [7:0]  OFS_MULTIFUNC    = 8'h0c;
  localparam logic [7:0]  OFS_EVENT_STATUS = 8'h10;
  localparam logic [7:0]  OFS_EVENT_MASK   = 8'h14;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
  localparam logic        HRESP_OKAY       = 1'h0;

  // ----------------------------------------------------------------
  // Pin edge selector codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } irqfb_edge_t;

  localparam logic [1:0]  EDGE_SELECT_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Control register layouts, bit 6/7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timerZeroIrqFlag;
    logic autoconvIrqFlag;
    logic pinIrqFlag;
    logic timerZeroIrqEnable;
    logic autoconvIrqEnable;
    logic pinIrqEnable;
    logic globalIrqGate;
  } irqfb_ctrl_a_t;

  typedef struct packed {
    logic lowVoltageIrqFlag;
    logic groupIrqFlag;
    logic serialIrqFlag;
    logic timerOneIrqFlag;
    logic lowVoltageIrqEnable;
    logic groupIrqEnable;
    logic serialIrqEnable;
    logic timerOneIrqEnable;
  } irqfb_ctrl_b_t;

  typedef struct packed {
    logic eepromIrqFlag;
    logic conversionDoneFlag;
    logic eepromIrqEnable;
    logic conversionDoneEnable;
  } irqfb_multifunc_t;

  localparam irqfb_ctrl_a_t    CTRL_A_RESET    = 7'h00;
  localparam irqfb_ctrl_b_t    CTRL_B_RESET    = 8'h00;
  localparam irqfb_multifunc_t MULTIFUNC_RESET = 4'h0;

  // Multi-function bit positions in the register word
  localparam int MF_EEPROM_FLAG_BIT = 6;
  localparam int MF_CONV_FLAG_BIT   = 4;
  localparam int MF_EEPROM_EN_BIT   = 2;
  localparam int MF_CONV_EN_BIT     = 0;

  // ----------------------------------------------------------------
  // Peripheral event pulses and vectors
  // ----------------------------------------------------------------
  typedef struct packed {
    logic eepromDone;
    logic conversionDone;
    logic lowVoltageEvent;
    logic serialEvent;
    logic timerOneOverflow;
    logic timerZeroOverflow;
    logic autoconvDone;
  } irqfb_events_t;

  typedef enum logic [2:0] {
    VEC_PIN      = 3'h0,
    VEC_AUTOCONV = 3'h1,
    VEC_TIMER0   = 3'h2,
    VEC_TIMER1   = 3'h3,
    VEC_SERIAL   = 3'h4,
    VEC_GROUP    = 3'h5,
    VEC_LOWV     = 3'h6
  } irqfb_vector_t;

  localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET   = 8'h00;

endpackage

//--- hw/irqfb_pin_edge.sv
// Synchroniser and edge qualifier for the external interrupt pin
module irqfb_pin_edge (
  // Clock and reset
  input  wire  logic                  clk,
  input  wire  logic                  reset_n,
  // Pin and selector
  input  wire  logic                  pinLevel,
  input  wire  irqfb_pkg::irqfb_edge_t edgeSel,
  // Qualified edge pulse
  output logic                        edgeHit
);
  import irqfb_pkg::*;

  logic syncFirst_r;
  logic syncSecond_r;
  logic prevLevel_r;
  logic edgeHit_r;
  logic hit;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then one stage of history
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncFirst_r  <= 1'b0;
      syncSecond_r <= 1'b0;
      prevLevel_r  <= 1'b0;
    end else begin
      syncFirst_r  <= pinLevel;          // RULE15
      syncSecond_r <= syncFirst_r;       // RULE15
      prevLevel_r  <= syncSecond_r;
    end
  end

  always_comb begin
    unique case (edgeSel)
      EDGE_OFF:  hit = 1'b0;                            // RULE1
      EDGE_RISE: hit = syncSecond_r & ~prevLevel_r;     // RULE1
      EDGE_FALL: hit = ~syncSecond_r & prevLevel_r;     // RULE1
      EDGE_BOTH: hit = syncSecond_r ^ prevLevel_r;      // RULE1
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edgeHit_r <= 1'b0;
    end else begin
      edgeHit_r <= hit;                  // RULE9
    end
  end

  assign edgeHit = edgeHit_r;

endmodule

//--- hw/irqfb_bank.sv
// Interrupt request flags, enables and vector request logic with AHB-Lite access
//
// Contract
// RULE1: Edge selector code 00 disables the pin interrupt, 01 rising, 10 falling, 11 both edges.
// RULE2: Control register A holds, bit 6 to 0, timer 0 flag, autoconv flag, pin flag, their enables, global gate.
// RULE3: Control register B holds, bit 7 to 0, low-voltage, group, serial, timer 1 flags, then their enables.
// RULE4: Every source has its own enable (1 enables) and its own flag (1 while pending).
// RULE5: Unimplemented bits in these registers read as zero and ignore writes.
// RULE6: Serial events set the serial flag and the serial enable gates that request.
// RULE7: Low-voltage detection sets its flag and its enable gates the request.
// RULE8: A separate register holds the conversion and EEPROM flags and enables feeding the group request.
// RULE9: The pin request comes from transitions on the pin as qualified by the edge selector.
// RULE10: A set flag raises its vector only when its enable is 1; a clear global gate blocks all vectors.
// RULE11: Taking an interrupt clears the global gate automatically.
// RULE12: No request is acknowledged while the return stack is full; it stays pending.
// RULE13: Serving the pin interrupt clears the pin flag automatically.
// RULE14: The group flag is set when a grouped source flag gets set while its own enable is 1.
// RULE15: The pin is synchronised before edge detection so each edge sets the flag once.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
module irqfb_bank (
  // Clock and reset
  input  wire  logic                     clk,
  input  wire  logic                     reset_n,
  // AHB-Lite slave
  input  wire  logic                     hsel,
  input  wire  logic [31:0]              haddr,
  input  wire  logic [1:0]               htrans,
  input  wire  logic                     hwrite,
  input  wire  logic [2:0]               hsize,
  input  wire  logic [31:0]              hwdata,
  input  wire  logic                     hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // External pin and peripheral events
  input  wire  logic                     extPinLevel,
  input  wire  irqfb_pkg::irqfb_events_t periphEvents,
  // Processor core
  input  wire  logic                     stackFull,
  input  wire  logic                     coreAck,
  output logic                           coreReqValid,
  output irqfb_pkg::irqfb_vector_t       coreVector,
  // Interrupt line
  output logic                           irqOut
);
  import irqfb_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                  busAccept;
  logic                  readAccept;
  logic                  statusRead;
  logic                  wrPend_r;
  logic [ADDR_DEC_W-1:0] wrAddr_r;
  logic [7:0]            wrByte;
  logic                  wrEdgeSel;
  logic                  wrCtrlA;
  logic                  wrCtrlB;
  logic                  wrMulti;
  logic                  wrMask;
  logic [31:0]           hrdata_r;
  logic [31:0]           readVal;

  irqfb_edge_t           edgeSel_r;
  irqfb_ctrl_a_t         ctrlA_r;
  irqfb_ctrl_a_t         ctrlA_nxt;
  irqfb_ctrl_b_t         ctrlB_r;
  irqfb_ctrl_b_t         ctrlB_nxt;
  irqfb_multifunc_t      multi_r;
  irqfb_multifunc_t      multi_nxt;
  logic [7:0]            status_r;
  logic [7:0]            mask_r;
  logic [7:0]            eventSet;

  logic                  pinHit;
  logic                  groupSet;
  logic                  vecValid_r;
  irqfb_vector_t         vector_r;
  logic                  pickValid;
  irqfb_vector_t         pickVec;
  logic                  takeAck;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] packMulti(irqfb_multifunc_t m);
    logic [7:0] w;
    w                     = 8'h00;
    w[MF_EEPROM_FLAG_BIT] = m.eepromIrqFlag;
    w[MF_CONV_FLAG_BIT]   = m.conversionDoneFlag;
    w[MF_EEPROM_EN_BIT]   = m.eepromIrqEnable;
    w[MF_CONV_EN_BIT]     = m.conversionDoneEnable;
    return w;
  endfunction

  function automatic logic isAddr(logic [ADDR_DEC_W-1:0] a, logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Zero wait states: registers are all flops, so no stall is needed
  assign hreadyout  = 1'b1;
  assign hresp      = HRESP_OKAY;
  assign busAccept  = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign readAccept = busAccept & ~hwrite;
  assign statusRead = readAccept & isAddr(haddr[ADDR_DEC_W-1:0], OFS_EVENT_STATUS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= busAccept & hwrite;
      if (busAccept) begin
        wrAddr_r <= haddr[ADDR_DEC_W-1:0];
      end
    end
  end

  // Only whole-word writes are issued; the low byte carries the register
  assign wrByte    = hwdata[7:0];
  assign wrEdgeSel = wrPend_r & isAddr(wrAddr_r, OFS_EDGE_SELECT);
  assign wrCtrlA   = wrPend_r & isAddr(wrAddr_r, OFS_CTRL_A);
  assign wrCtrlB   = wrPend_r & isAddr(wrAddr_r, OFS_CTRL_B);
  assign wrMulti   = wrPend_r & isAddr(wrAddr_r, OFS_MULTIFUNC);
  assign wrMask    = wrPend_r & isAddr(wrAddr_r, OFS_EVENT_MASK);

  always_comb begin
    readVal = 32'h0000_0000;
    unique case (haddr[ADDR_DEC_W-1:0])
      OFS_EDGE_SELECT:  readVal = {30'h0000_0000, edgeSel_r};   // RULE5
      OFS_CTRL_A:       readVal = {25'h000_0000, ctrlA_r};      // RULE5
      OFS_CTRL_B:       readVal = {24'h00_0000, ctrlB_r};
      OFS_MULTIFUNC:    readVal = {24'h00_0000, packMulti(multi_r)}; // RULE5
      OFS_EVENT_STATUS: readVal = {24'h00_0000, status_r};
      OFS_EVENT_MASK:   readVal = {24'h00_0000, mask_r};
      default:          readVal = 32'h0000_0000;
    endcase
  end

  // Read data sampled at the address phase, shown through the data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (readAccept) begin
      hrdata_r <= readVal;
    end
  end

  assign hrdata = hrdata_r;

  // ----------------------------------------------------------------
  // Pin edge selector and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edgeSel_r <= EDGE_OFF;
    end else if (wrEdgeSel) begin
      edgeSel_r <= irqfb_edge_t'(wrByte[1:0]);   // RULE5
    end
  end

  irqfb_pin_edge u_pin_edge (
    .clk      (clk),
    .reset_n  (reset_n),
    .pinLevel (extPinLevel),
    .edgeSel  (edgeSel_r),
    .edgeHit  (pinHit)
  );

  // ----------------------------------------------------------------
  // Control register A
  // ----------------------------------------------------------------
  // Order: software write, then acknowledge clear, then hardware set
  always_comb begin
    ctrlA_nxt = ctrlA_r;
    if (wrCtrlA) begin
      ctrlA_nxt = irqfb_ctrl_a_t'(wrByte[6:0]);   // RULE2 RULE4
    end
    if (takeAck) begin
      ctrlA_nxt.globalIrqGate = 1'b0;             // RULE11
      unique case (vector_r)
        VEC_PIN:      ctrlA_nxt.pinIrqFlag       = 1'b0;   // RULE13
        VEC_AUTOCONV: ctrlA_nxt.autoconvIrqFlag  = 1'b0;
        VEC_TIMER0:   ctrlA_nxt.timerZeroIrqFlag = 1'b0;
        default:      ctrlA_nxt.globalIrqGate    = 1'b0;
      endcase
    end
    if (pinHit) begin
      ctrlA_nxt.pinIrqFlag = 1'b1;                // RULE9
    end
    if (periphEvents.autoconvDone) begin
      ctrlA_nxt.autoconvIrqFlag = 1'b1;
    end
    if (periphEvents.timerZeroOverflow) begin
      ctrlA_nxt.timerZeroIrqFlag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlA_r <= CTRL_A_RESET;
    end else begin
      ctrlA_r <= ctrlA_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Multi-function register
  // ----------------------------------------------------------------
  always_comb begin
    multi_nxt = multi_r;
    if (wrMulti) begin
      multi_nxt.eepromIrqFlag        = wrByte[MF_EEPROM_FLAG_BIT];   // RULE8
      multi_nxt.conversionDoneFlag   = wrByte[MF_CONV_FLAG_BIT];
      multi_nxt.eepromIrqEnable      = wrByte[MF_EEPROM_EN_BIT];
      multi_nxt.conversionDoneEnable = wrByte[MF_CONV_EN_BIT];
    end
    if (periphEvents.eepromDone) begin
      multi_nxt.eepromIrqFlag = 1'b1;
    end
    if (periphEvents.conversionDone) begin
      multi_nxt.conversionDoneFlag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      multi_r <= MULTIFUNC_RESET;
    end else begin
      multi_r <= multi_nxt;
    end
  end

  // Grouped source events feed the shared group request only through their enables
  assign groupSet = (periphEvents.conversionDone & multi_r.conversionDoneEnable)
                  | (periphEvents.eepromDone & multi_r.eepromIrqEnable);   // RULE14 RULE8

  // ----------------------------------------------------------------
  // Control register B
  // ----------------------------------------------------------------
  always_comb begin
    ctrlB_nxt = ctrlB_r;
    if (wrCtrlB) begin
      ctrlB_nxt = irqfb_ctrl_b_t'(wrByte);        // RULE3 RULE4
    end
    if (takeAck) begin
      unique case (vector_r)
        VEC_TIMER1: ctrlB_nxt.timerOneIrqFlag   = 1'b0;
        VEC_SERIAL: ctrlB_nxt.serialIrqFlag     = 1'b0;
        VEC_GROUP:  ctrlB_nxt.groupIrqFlag      = 1'b0;
        VEC_LOWV:   ctrlB_nxt.lowVoltageIrqFlag = 1'b0;
        default:    ctrlB_nxt.timerOneIrqFlag   = ctrlB_nxt.timerOneIrqFlag;
      endcase
    end
    if (periphEvents.timerOneOverflow) begin
      ctrlB_nxt.timerOneIrqFlag = 1'b1;
    end
    if (periphEvents.serialEvent) begin
      ctrlB_nxt.serialIrqFlag = 1'b1;             // RULE6
    end
    if (periphEvents.lowVoltageEvent) begin
      ctrlB_nxt.lowVoltageIrqFlag = 1'b1;         // RULE7
    end
    if (groupSet) begin
      ctrlB_nxt.groupIrqFlag = 1'b1;              // RULE14
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlB_r <= CTRL_B_RESET;
    end else begin
      ctrlB_r <= ctrlB_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Vector arbitration
  // ----------------------------------------------------------------
  // Fixed priority, pin highest, low-voltage lowest
  always_comb begin
    pickValid = 1'b1;
    if (ctrlA_r.pinIrqFlag & ctrlA_r.pinIrqEnable) begin                  // RULE10
      pickVec = VEC_PIN;
    end else if (ctrlA_r.autoconvIrqFlag & ctrlA_r.autoconvIrqEnable) begin
      pickVec = VEC_AUTOCONV;
    end else if (ctrlA_r.timerZeroIrqFlag & ctrlA_r.timerZeroIrqEnable) begin
      pickVec = VEC_TIMER0;
    end else if (ctrlB_r.timerOneIrqFlag & ctrlB_r.timerOneIrqEnable) begin
      pickVec = VEC_TIMER1;
    end else if (ctrlB_r.serialIrqFlag & ctrlB_r.serialIrqEnable) begin   // RULE6
      pickVec = VEC_SERIAL;
    end else if (ctrlB_r.groupIrqFlag & ctrlB_r.groupIrqEnable) begin
      pickVec = VEC_GROUP;
    end else if (ctrlB_r.lowVoltageIrqFlag & ctrlB_r.lowVoltageIrqEnable) begin // RULE7
      pickVec = VEC_LOWV;
    end else begin
      pickValid = 1'b0;
      pickVec   = VEC_PIN;
    end
  end

  // A flag cleared this cycle still shows one cycle; the gate already hides it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vecValid_r <= 1'b0;
      vector_r   <= VEC_PIN;
    end else begin
      vecValid_r <= pickValid & ~takeAck;
      vector_r   <= pickVec;
    end
  end

  assign coreReqValid = vecValid_r & ctrlA_r.globalIrqGate & ~stackFull;   // RULE10 RULE12
  assign coreVector   = vector_r;
  assign takeAck      = coreAck & coreReqValid;                           // RULE12

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------------------------------
  assign eventSet = {groupSet,
                     periphEvents.lowVoltageEvent,
                     periphEvents.serialEvent,
                     periphEvents.timerOneOverflow,
                     periphEvents.timerZeroOverflow,
                     periphEvents.autoconvDone,
                     pinHit,
                     1'b0};

  // Set wins over the read clear, so no event is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= EVENT_STATUS_RESET;
    end else begin
      status_r <= (status_r & ~{8{statusRead}}) | eventSet;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= EVENT_MASK_RESET;
    end else if (wrMask) begin
      mask_r <= wrByte;
    end
  end

  assign irqOut = |(status_r & mask_r);

endmodule

//--- testbench/irqfb_bank_monitor.sv
// Port-level checker for the interrupt request and enable bank
module irqfb_bank_monitor
  import irqfb_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Core side
  input wire logic        stackFull,
  input wire logic        coreAck,
  input wire logic        coreReqValid
);
  logic       busGo;
  logic       rdGo;
  logic [7:0] ofs;

  assign busGo = hsel && hready && htrans[1];
  assign rdGo  = busGo && !hwrite;
  assign ofs   = haddr[7:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Read data shape
  // ----------------------------------------------------------------
  property p_sel_rd;
    rdGo && ofs == OFS_EDGE_SELECT |=> hrdata[31:2] == 30'h0;
  endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("edge select spare bits");
  property p_ctla_rd;
    rdGo && ofs == OFS_CTRL_A |=> hrdata[31:7] == 25'h0;
  endproperty
  a_ctla_rd: assert property (p_ctla_rd) else $error("control A spare bits");
  property p_ctlb_rd;
    rdGo && ofs == OFS_CTRL_B |=> hrdata[31:8] == 24'h0;
  endproperty
  a_ctlb_rd: assert property (p_ctlb_rd) else $error("control B spare bits");
  property p_mf_rd;
    rdGo && ofs == OFS_MULTIFUNC |=> (hrdata & 32'hffffffaa) == 32'h0;
  endproperty
  a_mf_rd: assert property (p_mf_rd) else $error("group register spare bits");
  property p_hole_rd;
    rdGo && ofs == 8'h18 |=> hrdata == 32'h0;
  endproperty
  a_hole_rd: assert property (p_hole_rd) else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // Core request
  // ----------------------------------------------------------------
  property p_stack;
    stackFull |-> !coreReqValid;
  endproperty
  a_stack: assert property (p_stack) else $error("request while stack full");
  property p_ack;
    coreAck && coreReqValid |=> !coreReqValid;
  endproperty
  a_ack: assert property (p_ack) else $error("request after ack");
  // Only software can reopen the gate, so quiet bus keeps it shut
  property p_gate;
    coreAck && coreReqValid && !busGo ##1 !busGo [*2] |=> !coreReqValid;
  endproperty
  a_gate: assert property (p_gate) else $error("gate reopened alone");
endmodule

bind irqfb_bank irqfb_bank_monitor i_mon (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .stackFull(stackFull), .coreAck(coreAck), .coreReqValid(coreReqValid)
);

//--- testbench/irqfb_core_model.sv
// Behavioural core and event sources facing the interrupt bank
module irqfb_core_model
  import irqfb_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Bench commands
  input  wire irqfb_pkg::irqfb_events_t evTrig,
  input  wire logic                     stackHold,
  input  wire logic [3:0]               ackDelay,
  // Bank side
  input  wire logic                     coreReqValid,
  output irqfb_pkg::irqfb_events_t      periphEvents,
  output logic                          stackFull,
  output logic                          coreAck
);
  logic [3:0] waitCnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periphEvents <= '0;
      stackFull    <= 1'b0;
    end else begin
      periphEvents <= evTrig;
      stackFull    <= stackHold;
    end
  end

  // A slow core waits ackDelay cycles on a standing request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt_r <= 4'h0;
      coreAck   <= 1'b0;
    end else begin
      coreAck <= 1'b0;
      if (!coreReqValid || coreAck) begin
        waitCnt_r <= 4'h0;
      end else if (waitCnt_r < ackDelay) begin
        waitCnt_r <= waitCnt_r + 4'h1;
      end else begin
        coreAck <= 1'b1;
      end
    end
  end
endmodule

//--- testbench/irqfb_bank_tb_top.sv
// Self-checking bench for the interrupt request and enable bank
module irqfb_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irqfb_pkg::*;

  logic          clk;
  logic          reset_n;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  logic          extPinLevel;
  irqfb_events_t evTrig;
  irqfb_events_t periphEvents;
  logic          stackHold;
  logic [3:0]    ackDelay;
  logic          stackFull;
  logic          coreAck;
  logic          coreReqValid;
  irqfb_vector_t coreVector;
  logic          irqOut;
  logic [31:0]   rd;
  int            badCount;
  int            checked;
  logic [7:0]    rOfs [6] = '{OFS_EDGE_SELECT, OFS_CTRL_A, OFS_CTRL_B, OFS_MULTIFUNC, OFS_EVENT_STATUS, 8'h18};
  logic [7:0]    rMsk [6] = '{8'h03, 8'h7f, 8'hff, 8'h55, 8'h00, 8'h00};
  logic [7:0]    eReg [7] = '{OFS_CTRL_A, OFS_CTRL_A, OFS_CTRL_B, OFS_CTRL_B, OFS_CTRL_B, OFS_MULTIFUNC, OFS_MULTIFUNC};
  logic [7:0]    eFlg [7] = '{8'h20, 8'h40, 8'h10, 8'h20, 8'h80, 8'h10, 8'h40};
  logic [7:0]    eSt  [7] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00, 8'h00};

  irqfb_bank i_dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extPinLevel(extPinLevel), .periphEvents(periphEvents), .stackFull(stackFull),
    .coreAck(coreAck), .coreReqValid(coreReqValid), .coreVector(coreVector), .irqOut(irqOut)
  );
  irqfb_core_model i_core (
    .clk(clk), .reset_n(reset_n), .evTrig(evTrig), .stackHold(stackHold), .ackDelay(ackDelay),
    .coreReqValid(coreReqValid), .periphEvents(periphEvents), .stackFull(stackFull), .coreAck(coreAck)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrapUp();
    if (badCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      chk("hready", 32'h1, {31'h0, hreadyout});
      wrapUp();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic fire(input irqfb_events_t ev);
    evTrig <= ev;
    tick(1);
    evTrig <= '0;
    tick(2);
  endtask
  task automatic pin(input logic v);
    extPinLevel <= v;
    tick(6);
  endtask
  task automatic ackChk(input irqfb_vector_t v);
    int n;
    n = 0;
    while (coreAck !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("ack", 32'h1, {31'h0, coreAck});
    if (coreAck !== 1'b1) wrapUp();
    chk("vector", {29'h0, v}, {29'h0, coreVector});
  endtask

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    extPinLevel = 1'b0;
    evTrig = '0;
    stackHold = 1'b1;
    ackDelay = 4'h1;
    badCount = 0;
    checked = 0;
    tick(2);
    reset_n <= 1'b1;
    // Stack held full so all-ones writes cannot start a request
    for (int i = 0; i < 6; i++) begin
      rdChk("reset", rOfs[i], 32'h0);
      wr(rOfs[i], 32'hffffffff);
      rdChk("rw bits", rOfs[i], {24'h0, rMsk[i]});
      wr(rOfs[i], 32'h0);
    end
    wr(OFS_EVENT_MASK, 32'hff);
    for (int i = 0; i < 7; i++) begin
      fire(irqfb_events_t'(7'h01 << i));
      chk("irq line", {31'h0, eSt[i] != 8'h0}, {31'h0, irqOut});
      rdChk("flag", eReg[i], {24'h0, eFlg[i]});
      rdChk("status", OFS_EVENT_STATUS, {24'h0, eSt[i]});
      wr(eReg[i], 32'h0);
      chk("irq clear", 32'h0, {31'h0, irqOut});
    end
    wr(OFS_MULTIFUNC, 32'h05);
    fire(irqfb_events_t'(7'h20));
    rdChk("group flag", OFS_CTRL_B, 32'h40);
    rdChk("group status", OFS_EVENT_STATUS, 32'h80);
    wr(OFS_CTRL_B, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_EDGE_SELECT, 32'(c));
      pin(1'b1);
      rdChk("pin rise", OFS_CTRL_A, {27'h0, c[0], 4'h0});
      wr(OFS_CTRL_A, 32'h0);
      pin(1'b0);
      rdChk("pin fall", OFS_CTRL_A, {27'h0, c[1], 4'h0});
      wr(OFS_CTRL_A, 32'h0);
    end
    rdChk("pin status", OFS_EVENT_STATUS, 32'h02);
    wr(OFS_EDGE_SELECT, 32'h1);
    wr(OFS_CTRL_A, 32'h03);
    pin(1'b1);
    chk("stack hold", 32'h0, {31'h0, coreReqValid});
    stackHold <= 1'b0;
    ackChk(VEC_PIN);
    rdChk("pin acked", OFS_CTRL_A, 32'h02);
    ackDelay <= 4'h9;
    wr(OFS_CTRL_A, 32'h08);
    fire(irqfb_events_t'(7'h02));
    chk("gate shut", 32'h0, {31'h0, coreReqValid});
    rdChk("recorded", OFS_CTRL_A, 32'h48);
    wr(OFS_CTRL_A, 32'h49);
    ackChk(VEC_TIMER0);
    tick(3);
    rdChk("timer acked", OFS_CTRL_A, 32'h08);
    wr(OFS_CTRL_B, 32'h22);
    wr(OFS_CTRL_A, 32'h01);
    ackChk(VEC_SERIAL);
    rdChk("serial acked", OFS_CTRL_B, 32'h02);
    wr(OFS_EVENT_MASK, 32'h0);
    fire(irqfb_events_t'(7'h04));
    chk("masked", 32'h0, {31'h0, irqOut});
    rdChk("kept status", OFS_EVENT_STATUS, 32'h1a);
    wrapUp();
  end
endmodule
